// ===== src/ascp_defs.vh
// Constants shared by the serial command port of the converter.
// Operation
// - 16-bit frames, MSB first, 4-bit command.
// - Codes 0-7 select channel, start conversion.
// - Code 8 powers down analog and reference.
// - Code 9 returns config word, bits 11-0.
// - Code A stores 12-bit config word.
// - Codes B,C,D select mid, low, high test.
// - Code E outputs buffered result, low nibble zero; here bits 15-12 come from the last conversion.
// - Config readback: bits 15-12 don't care.
// - Conversion result in output bits 15-4.
// - Unipolar straight binary, 000h to FFFh.
// - First conversion after wake is invalid.
// - Frame sync high: chip-select fall starts cycle.
// - Frame sync used: its fall starts cycle.
// - Readback valid only in single-shot mode; here mode bits 6-5 are not decoded and readback is given in every mode.
// - Channel switching is break-before-make.
// - 12-bit successive approximation, one bit per step.
// - Capture rising edges, or falling with frame sync.
// - Output floats while deselected until first bit.
`ifndef ASCP_DEFS_VH
`define ASCP_DEFS_VH
`define ASCP_FRAME_BITS 5'h10
`define ASCP_CMD_MSB 15
`define ASCP_CMD_LSB 12
`define ASCP_CMD_PDOWN 4'h8
`define ASCP_CMD_RDCFG 4'h9
`define ASCP_CMD_WRCFG 4'hA
`define ASCP_CMD_TMID 4'hB
`define ASCP_CMD_TLOW 4'hC
`define ASCP_CMD_THIGH 4'hD
`define ASCP_CMD_FIFO 4'hE
`define ASCP_CFG_RESET 12'h000
`define ASCP_MODE_MSB 6
`define ASCP_MODE_LSB 5
`define ASCP_MODE_SINGLE 2'b00
`define ASCP_SAR_STEPS 4'hC
`define ASCP_SRC_MID 4'h8
`define ASCP_SRC_LOW 4'h9
`define ASCP_SRC_HIGH 4'hA
`define ASCP_SRC_NONE 4'hF
`endif

// ===== src/ascp_sync.v
// Two-flip-flop synchroniser for a group of external inputs.
`default_nettype none
module ascp_sync #(
	parameter W = 4
) (
	input wire clock,
	input wire rst_n,
	input wire ce,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_q
);
	reg [W-1:0] meta_q;
	// Reset loads the idle-high level; a caller inverts any pin that idles low so no false edge follows reset.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end
		else if (ce)
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== src/ascp_sar.v
// Successive-approximation sequencer driving a stepped DAC against a comparator.
`include "ascp_defs.vh"
`default_nettype none
module ascp_sar (
	input wire clock,
	input wire rst_n,
	input wire ce,
	input wire start,
	input wire comp_hi,
	output reg [11:0] dac_q,
	output reg busy_q,
	output reg done_q,
	output reg [11:0] result_q
);
	reg [3:0] step_q;
	// One result bit resolved per step, MSB first, by trial setting the bit.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_q <= 12'h000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			step_q <= 4'h0;
			result_q <= 12'h000;
		end
		else if (ce)
		begin
			done_q <= 1'b0;
			if (start && !busy_q)
			begin
				busy_q <= 1'b1;
				step_q <= 4'h0;
				dac_q <= 12'h800;
			end
			else if (busy_q)
			begin
				if (!comp_hi)
					dac_q[4'd11 - step_q] <= 1'b0;
				if (step_q == `ASCP_SAR_STEPS - 4'h1)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					result_q <= comp_hi ? dac_q : (dac_q & ~(12'h800 >> step_q));
				end
				else
				begin
					step_q <= step_q + 4'h1;
					dac_q[4'd10 - step_q] <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/ascp_top.v
// Serial command port: frame capture, command decode, output shifter and mux control.
`include "ascp_defs.vh"
`default_nettype none
module ascp_top (
	input wire clock,
	input wire arst_n,
	input wire ce,
	input wire cs_n,
	input wire sclk,
	input wire sdi,
	input wire frame_sync_in,
	input wire comp_hi,
	input wire [11:0] fifo_data,
	output wire fifo_pop,
	output reg sdo_q,
	output reg sdo_oe_n_q,
	output reg [3:0] mux_sel_q,
	output reg mux_en_q,
	output wire [11:0] dac_code,
	output reg pdown_q,
	output reg [11:0] config_word_q,
	output reg result_valid_q,
	output reg [11:0] result_q
);
	// ==========================================================
	// Reset release and input synchronisers
	// ==========================================================
	reg [1:0] rst_pipe_q;
	wire rst_n;
	wire [3:0] pins;
	wire cs_s;
	wire sclk_s;
	wire sdi_s;
	wire fs_s;
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rst_pipe_q <= 2'b00;
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
	end
	assign rst_n = rst_pipe_q[1];

	ascp_sync #(.W(4)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.async_in({cs_n, ~sclk, sdi, frame_sync_in}),
		.sync_q(pins)
	);
	assign cs_s = pins[3];
	// The serial clock idles low, so it is carried inverted through the idle-high synchroniser.
	assign sclk_s = ~pins[2];
	assign sdi_s = pins[1];
	assign fs_s = pins[0];

	// ==========================================================
	// Edge detection and cycle start
	// ==========================================================
	reg cs_d1_q;
	reg sclk_d1_q;
	reg fs_d1_q;
	reg fs_mode_q;
	reg active_q;
	reg [4:0] bit_cnt_q;
	reg [15:0] shift_in_q;
	reg [15:0] shift_out_q;
	reg first_out_q;
	wire cs_fall;
	wire fs_fall;
	wire sclk_rise;
	wire sclk_fall;
	wire start_cycle;
	wire cap_edge;
	wire upd_edge;
	wire [15:0] frame_word;
	wire [3:0] cmd;
	wire frame_done;

	assign cs_fall = cs_d1_q & ~cs_s;
	assign fs_fall = fs_d1_q & ~fs_s & ~cs_s;
	assign sclk_rise = ~sclk_d1_q & sclk_s;
	assign sclk_fall = sclk_d1_q & ~sclk_s;
	// Frame sync high at the chip-select fall selects the plain serial mode.
	assign start_cycle = (cs_fall & fs_s) | (fs_fall & fs_mode_q);
	assign cap_edge = fs_mode_q ? sclk_fall : sclk_rise;
	assign upd_edge = fs_mode_q ? sclk_rise : sclk_fall;
	assign frame_word = {shift_in_q[14:0], sdi_s};
	assign cmd = frame_word[`ASCP_CMD_MSB:`ASCP_CMD_LSB];
	assign frame_done = active_q & cap_edge & (bit_cnt_q == `ASCP_FRAME_BITS - 5'h01);

	// Output word is chosen from the command seen at the fourth captured bit.
	function [15:0] out_word;
		input [3:0] c;
		input [11:0] cfg;
		input [11:0] res;
		input [11:0] fifo;
		begin
			if (c == `ASCP_CMD_RDCFG)
				out_word = {4'h0, cfg};
			else if (c == `ASCP_CMD_FIFO)
				out_word = {fifo, 4'h0};
			else
				out_word = {res, 4'h0};
		end
	endfunction

	// ==========================================================
	// Command decode helpers
	// ==========================================================
	// Channel selects and test-input selects both start a conversion.
	function is_select;
		input [3:0] c;
		begin
			is_select = (c[3] == 1'b0) || (c == `ASCP_CMD_TMID) || (c == `ASCP_CMD_TLOW) ||
				(c == `ASCP_CMD_THIGH);
		end
	endfunction

	// Maps a select command onto the multiplexer code; test inputs sit above the channels.
	function [3:0] sel_code;
		input [3:0] c;
		begin
			if (c[3] == 1'b0)
				sel_code = c;
			else
				sel_code = `ASCP_SRC_MID + (c - `ASCP_CMD_TMID);
		end
	endfunction

	// ==========================================================
	// Frame capture and serial output
	// ==========================================================
	reg [11:0] last_result_q;
	wire [3:0] early_cmd;
	assign early_cmd = {shift_in_q[2:0], sdi_s};
	// Gated by the enable so a frozen block does not pop the buffer on every cycle.
	assign fifo_pop = ce & active_q & cap_edge & (bit_cnt_q == 5'h03) & (early_cmd == `ASCP_CMD_FIFO);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_d1_q <= 1'b1;
			sclk_d1_q <= 1'b0;
			fs_d1_q <= 1'b1;
			fs_mode_q <= 1'b0;
			active_q <= 1'b0;
			bit_cnt_q <= 5'h00;
			shift_in_q <= 16'h0000;
			shift_out_q <= 16'h0000;
			first_out_q <= 1'b0;
			sdo_q <= 1'b0;
			sdo_oe_n_q <= 1'b1;
		end
		else if (ce)
		begin
			cs_d1_q <= cs_s;
			sclk_d1_q <= sclk_s;
			fs_d1_q <= fs_s;
			if (cs_fall)
				fs_mode_q <= ~fs_s;
			if (cs_s)
			begin
				active_q <= 1'b0;
				sdo_oe_n_q <= 1'b1;
			end
			else if (start_cycle)
			begin
				active_q <= 1'b1;
				bit_cnt_q <= 5'h00;
				shift_in_q <= 16'h0000;
				shift_out_q <= {last_result_q, 4'h0};
				first_out_q <= 1'b1;
				sdo_oe_n_q <= 1'b1;
			end
			else if (active_q)
			begin
				if (first_out_q)
				begin
					// The MSB appears once the cycle has started; the pin stops floating then.
					first_out_q <= 1'b0;
					sdo_q <= shift_out_q[15];
					sdo_oe_n_q <= 1'b0;
				end
				if (cap_edge)
				begin
					shift_in_q <= frame_word;
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == 5'h03)
						shift_out_q <= out_word(early_cmd, config_word_q, last_result_q, fifo_data);
					if (frame_done)
						active_q <= 1'b0;
				end
				else if (upd_edge && !first_out_q && bit_cnt_q != 5'h00)
				begin
					sdo_q <= shift_out_q[4'd15 - bit_cnt_q[3:0]];
				end
			end
			else if (!first_out_q && bit_cnt_q == `ASCP_FRAME_BITS)
			begin
				sdo_oe_n_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Command execution, multiplexer and conversion control
	// ==========================================================
	localparam ST_IDLE = 2'b00;
	localparam ST_BREAK = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam ST_WAIT = 2'b11;
	reg [1:0] state_q;
	reg [3:0] pend_sel_q;
	reg first_conv_q;
	wire sar_busy;
	wire sar_done;
	wire [11:0] sar_result;
	wire sar_start;
	assign sar_start = (state_q == ST_CONV);

	ascp_sar u_sar (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.start(sar_start),
		.comp_hi(comp_hi),
		.dac_q(dac_code),
		.busy_q(sar_busy),
		.done_q(sar_done),
		.result_q(sar_result)
	);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			pend_sel_q <= `ASCP_SRC_NONE;
			mux_sel_q <= `ASCP_SRC_NONE;
			mux_en_q <= 1'b0;
			pdown_q <= 1'b0;
			config_word_q <= `ASCP_CFG_RESET;
			first_conv_q <= 1'b1;
			result_valid_q <= 1'b0;
			result_q <= 12'h000;
			last_result_q <= 12'h000;
		end
		else if (ce)
		begin
			case (state_q)
			ST_BREAK:
			begin
				// Disconnect for one cycle before joining the next input.
				mux_en_q <= 1'b0;
				mux_sel_q <= pend_sel_q;
				state_q <= ST_CONV;
			end
			ST_CONV:
			begin
				mux_en_q <= 1'b1;
				state_q <= ST_WAIT;
			end
			ST_WAIT:
			begin
				if (sar_done)
				begin
					last_result_q <= sar_result;
					result_q <= sar_result;
					result_valid_q <= ~first_conv_q;
					first_conv_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			end
			default:
			begin
				state_q <= ST_IDLE;
			end
			endcase
			// Decoded after the sequencer so a result finishing in the same cycle is still taken,
			// while a new command and a fresh wake-up mark win over the sequencer's own updates.
			if (frame_done)
			begin
				if (is_select(cmd))
				begin
					pend_sel_q <= sel_code(cmd);
					if (pdown_q)
						first_conv_q <= 1'b1;
					pdown_q <= 1'b0;
					state_q <= ST_BREAK;
				end
				else if (cmd == `ASCP_CMD_PDOWN)
				begin
					pdown_q <= 1'b1;
					mux_en_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				else if (cmd == `ASCP_CMD_WRCFG)
					config_word_q <= frame_word[11:0];
				// Reserved code F falls through with no effect.
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/ascp_host_model.sv
// Host serial port model framing 16-bit words in plain or frame-sync mode.
`default_nettype none
module ascp_host_model (
	input wire logic clock,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	output logic frame_sync_in,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{cs_n, sclk, sdi, frame_sync_in} = 4'b1001;
	end
	// The link clock stands low between frames; a released data line flips so stale bits are never reused.
	task automatic xfer(input logic [15:0] w, input logic dsp, output logic [15:0] r);
		@(posedge clock);
		#2 frame_sync_in = !dsp;
		#160 cs_n = 0;
		if (dsp)
		begin
			#160 frame_sync_in = 1;
			#160 frame_sync_in = 0;
		end
		for (int i = 15; i >= 0; i--)
		begin
			#160 sdi = w[i];
			sclk = dsp;
			#160 r[i] = sdo;
			sclk = !dsp;
		end
		#160 sclk = 0;
		sdi = !sdi;
		#160 cs_n = 1;
		frame_sync_in = 1;
	endtask
endmodule
`default_nettype wire

// ===== tb/ascp_top_assertions.sv
// Concurrent checks on the ports of the serial command port.
`default_nettype none
module ascp_top_assertions (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cs_n,
	input wire logic frame_sync_in,
	input wire logic fifo_pop,
	input wire logic sdo_oe_n_q,
	input wire logic [3:0] mux_sel_q,
	input wire logic mux_en_q,
	input wire logic pdown_q,
	input wire logic result_valid_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence spi_start_s;
		$fell(cs_n) && frame_sync_in && ce ##1 (!cs_n && ce) [*5];
	endsequence
	sequence dsp_start_s;
		!cs_n && $fell(frame_sync_in) && ce ##1 (!cs_n && ce) [*5];
	endsequence
	AST_OE_FLOAT: assert property ((cs_n && ce) [*5] |-> sdo_oe_n_q)
		else $error("serial output driven while deselected");
	AST_SPI_START: assert property (spi_start_s |-> !sdo_oe_n_q)
		else $error("select fall did not open a frame");
	AST_DSP_START: assert property (dsp_start_s |-> !sdo_oe_n_q)
		else $error("frame sync fall did not open a frame");
	AST_BBM_SEL: assert property ($changed(mux_sel_q) |-> !mux_en_q)
		else $error("input changed while connected");
	AST_BBM_EN: assert property ($rose(mux_en_q) |-> $stable(mux_sel_q))
		else $error("input connected while changing");
	AST_SEL_RANGE: assert property (mux_en_q |-> mux_sel_q <= 4'hA)
		else $error("connected to no valid input");
	AST_POP_ONE: assert property (fifo_pop |=> !fifo_pop)
		else $error("buffer pop longer than one cycle");
	AST_POP_CE: assert property (!ce |-> !fifo_pop)
		else $error("buffer pop while frozen");
	AST_VALID_PD: assert property ($rose(result_valid_q) |-> !pdown_q)
		else $error("result flagged valid in power down");
endmodule
bind ascp_top ascp_top_assertions chk (.clock(clock), .arst_n(arst_n), .ce(ce), .cs_n(cs_n),
	.frame_sync_in(frame_sync_in), .fifo_pop(fifo_pop), .sdo_oe_n_q(sdo_oe_n_q), .mux_sel_q(mux_sel_q),
	.mux_en_q(mux_en_q), .pdown_q(pdown_q), .result_valid_q(result_valid_q));
`default_nettype wire

// ===== tb/tb_ascp_top.sv
// Self-checking bench for the serial command port.
`default_nettype none
module tb_ascp_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, arst_n, ce, cs_n, sclk, sdi, frame_sync_in, comp_hi, fifo_pop, sdo_q, sdo_oe_n_q;
	logic mux_en_q, pdown_q, result_valid_q;
	logic [3:0] mux_sel_q;
	logic [11:0] fifo_data, dac_code, config_word_q, result_q;
	logic [15:0] r;
	wire sdo_pin;
	int miscompares, check_count, pops;
	// Analog level seen by the comparator for each mux select.
	function automatic logic [11:0] level(input logic [3:0] s);
		case (s)
			4'h8: return 12'h800;
			4'h9: return 12'h000;
			4'hA: return 12'hFFF;
			default: return {s[2:0], 9'h15B};
		endcase
	endfunction
	assign comp_hi = level(mux_sel_q) >= dac_code;
	assign sdo_pin = sdo_oe_n_q ? 1'bz : sdo_q;
	ascp_top uut (.clock(clock), .arst_n(arst_n), .ce(ce), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.frame_sync_in(frame_sync_in), .comp_hi(comp_hi), .fifo_data(fifo_data), .fifo_pop(fifo_pop),
		.sdo_q(sdo_q), .sdo_oe_n_q(sdo_oe_n_q), .mux_sel_q(mux_sel_q), .mux_en_q(mux_en_q),
		.dac_code(dac_code), .pdown_q(pdown_q), .config_word_q(config_word_q),
		.result_valid_q(result_valid_q), .result_q(result_q));
	ascp_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .frame_sync_in(frame_sync_in),
		.sdo(sdo_pin));
	initial
	begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock)
	begin
		if (fifo_pop === 1'b1)
			pops <= pops + 1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_config;
		host.xfer(16'hA000, 0, r);
		chk({4'h0, config_word_q}, 16'h0000);
		host.xfer(16'hAA19, 0, r);
		chk({4'h0, config_word_q}, 16'h0A19);
		host.xfer(16'h9000, 0, r);
		chk({4'h0, r[11:0]}, 16'h0A19);
		host.xfer(16'hA183, 1, r);
		chk({4'h0, config_word_q}, 16'h0183);
		host.xfer(16'hF555, 0, r);
		chk({mux_sel_q, config_word_q}, 16'hF183);
	endtask
	// A frame sent while the enable is low must leave every register untouched.
	task automatic t_freeze;
		ce = 0;
		host.xfer(16'hAFFF, 0, r);
		ce = 1;
		chk({4'h0, config_word_q}, 16'h0183);
		chk(pops[15:0], 16'h0000);
	endtask
	// Conversions alternate framing modes; read-back is judged in plain mode only.
	task automatic t_conv;
		logic [3:0] c[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hD};
		logic [11:0] prev;
		logic [3:0] sel;
		host.xfer(16'h8000, 0, r);
		chk({15'h0, pdown_q}, 16'h0001);
		for (int k = 0; k < 11; k++)
		begin
			sel = c[k] < 4'h8 ? c[k] : c[k] - 4'h3;
			host.xfer({c[k], 12'h000}, k[0], r);
			chk({12'h0, mux_sel_q}, {12'h0, sel});
			if (k > 0 && !k[0])
				chk({r[15:4], 4'h0}, {prev, 4'h0});
			repeat (30) @(posedge clock);
			chk({4'h0, result_q}, {4'h0, level(sel)});
			chk({15'h0, result_valid_q}, {15'h0, 1'(k != 0)});
			prev = level(sel);
		end
	endtask
	task automatic t_fifo;
		host.xfer(16'hE000, 0, r);
		chk({4'h0, r[11:0]}, 16'h03B0);
		chk(pops[15:0], 16'h0001);
	endtask
	initial
	begin
		{arst_n, ce} = 2'b01;
		fifo_data = 12'hC3B;
		repeat (10) @(posedge clock);
		#2 arst_n = 1;
		repeat (8) @(posedge clock);
		t_config();
		t_freeze();
		t_conv();
		t_fifo();
		wrap_up();
	end
	initial
	begin
		#1_000_000;
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
